// File: rtl/rti_rule_table.sv
`timescale 1ns/10ps

// Behaviour
// - select 010 in bits 7:5, port in nibble
// - ports one to five own separate tables
// - offset register picks the per-port byte location
// - select bit 4 sets read or write direction
// - control bit 4: 1 write, 0 read
// - control bits 3:0 give entry, reset zero
// - control bit 5 low while read busy
// - host polls bit 6 before refilling buffer
// - byte enables at offsets 0x10 and 0x11
// - odd-byte enables transfer only odd bytes
// - writing control with bit 4 clear reads
// - host reads buffer bytes 0x00 to 0x0d
// - writing control with bit 4 set commits
// - filter option bit 0 picks ring filtering
// - enable bit i covers byte 0x0d minus i
module rti_rule_table
	import rti_pkg::*;
(
	input  wire logic       REF_CLK,
	input  wire logic       RST,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	output logic            REG_RVALID,
	output logic      [4:0] RING_FILTER_SINGLE
);

	logic [7:0]   select;
	logic [7:0]   offset;
	logic [7:0]   hold [0:NUM_PORTS-1][0:ENTRY_BYTES-1];
	logic [13:0]  byte_en [0:NUM_PORTS-1];
	logic [4:0]   ctl_op;
	logic [3:0]   ctl_entry [0:NUM_PORTS-1];
	logic [4:0]   read_done;
	logic [4:0]   write_done;
	rti_state_t   state;
	logic [2:0]   cur_port;
	logic [3:0]   cur_entry;
	logic         cur_wr;
	logic [111:0] mem_rdata;
	logic [111:0] mem_wdata;
	logic         port_ok;
	logic [2:0]   pidx;
	logic         data_wr;
	logic         data_rd;
	logic         trig;
	logic [7:0]   next_rdata;

	// -----------------------------------------------------------------
	// select decode
	// -----------------------------------------------------------------
	// table type 010 and a port number 1..5 open a per-port table
	assign port_ok = select[SEL_TABLE_MSB:SEL_TABLE_LSB] == SEL_TABLE_RULES
		&& select[3:0] >= PORT_FIRST && select[3:0] <= PORT_LAST;
	assign pidx    = 3'(select[3:0] - PORT_FIRST);
	// direction bit gates data writes versus data reads
	assign data_wr = REG_WR && REG_ADDR == ADDR_DATA && port_ok
		&& !select[SEL_DIR_BIT];
	assign data_rd = REG_RD && REG_ADDR == ADDR_DATA && port_ok
		&& select[SEL_DIR_BIT];
	// control write starts an entry operation when idle
	assign trig    = data_wr && offset == OFS_CONTROL
		&& state == ST_IDLE;

	// -----------------------------------------------------------------
	// select and offset registers
	// -----------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			select <= RST_SELECT;
		end else if (REG_WR && REG_ADDR == ADDR_SELECT) begin
			select <= REG_WDATA;
		end
	end

	// offset steps after each data access to allow bursts
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			offset <= RST_OFFSET;
		end else if (REG_WR && REG_ADDR == ADDR_OFFSET) begin
			offset <= REG_WDATA;
		end else if (data_wr || data_rd) begin
			offset <= offset + 8'h01;
		end
	end

	// -----------------------------------------------------------------
	// per-port configuration: enables, control, filter option
	// -----------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				byte_en[p]   <= RST_BE;
				ctl_entry[p] <= RST_ENTRY;
			end
			ctl_op             <= {NUM_PORTS{RST_OP}};
			RING_FILTER_SINGLE <= {NUM_PORTS{RST_FILTER}};
		end else if (data_wr) begin
			unique case (offset)
				OFS_BE_HIGH: byte_en[pidx][13:8] <= REG_WDATA[5:0];
				OFS_BE_LOW:  byte_en[pidx][7:0]  <= REG_WDATA;
				OFS_CONTROL: begin
					if (state == ST_IDLE) begin
						ctl_op[pidx]    <= REG_WDATA[CTL_OP_BIT];
						ctl_entry[pidx] <= REG_WDATA[3:0];
					end
				end
				OFS_FILTER: RING_FILTER_SINGLE[pidx] <= REG_WDATA[0];
				default: ;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// entry operation sequencer
	// -----------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state     <= ST_IDLE;
			cur_port  <= 3'h0;
			cur_entry <= 4'h0;
			cur_wr    <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (trig) begin
						state     <= ST_ACCESS;
						cur_port  <= pidx;
						cur_entry <= REG_WDATA[3:0];
						cur_wr    <= REG_WDATA[CTL_OP_BIT];
					end
				end
				ST_ACCESS: state <= ST_FINISH;
				ST_FINISH: state <= ST_IDLE;
				default:   state <= ST_IDLE;
			endcase
		end
	end

	// completion flags: low from request until the operation ends
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			read_done  <= {NUM_PORTS{RST_RDONE}};
			write_done <= {NUM_PORTS{RST_WDONE}};
		end else if (trig) begin
			if (REG_WDATA[CTL_OP_BIT]) begin
				write_done[pidx] <= 1'b0;
			end else begin
				read_done[pidx] <= 1'b0;
			end
		end else if (state == ST_FINISH) begin
			if (cur_wr) begin
				write_done[cur_port] <= 1'b1;
			end else begin
				read_done[cur_port] <= 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// holding buffer
	// -----------------------------------------------------------------
	// a finished read copies only the enabled bytes; it wins over host
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int b = 0; b < ENTRY_BYTES; b++) begin
					hold[p][b] <= 8'h00;
				end
			end
		end else if (state == ST_FINISH && !cur_wr) begin
			for (int b = 0; b < ENTRY_BYTES; b++) begin
				if (byte_en[cur_port][ENTRY_BYTES-1-b]) begin
					hold[cur_port][b] <= mem_rdata[8*b +: 8];
				end
			end
		end else if (data_wr && offset <= OFS_BYTE_LAST) begin
			hold[pidx][4'(offset)] <= REG_WDATA;
		end
	end

	always_comb begin
		mem_wdata = '0;
		for (int b = 0; b < ENTRY_BYTES; b++) begin
			mem_wdata[8*b +: 8] = hold[cur_port][b];
		end
	end

	rti_entry_mem u_mem (
		.clk      (REF_CLK),
		.we       (state == ST_ACCESS && cur_wr),
		.port_idx (cur_port),
		.entry    (cur_entry),
		.byte_en  (byte_en[cur_port]),
		.wdata    (mem_wdata),
		.rdata    (mem_rdata)
	);

	// -----------------------------------------------------------------
	// read data path
	// -----------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (REG_ADDR == ADDR_SELECT) begin
			next_rdata = select;
		end else if (REG_ADDR == ADDR_OFFSET) begin
			next_rdata = offset;
		end else if (data_rd) begin
			if (offset <= OFS_BYTE_LAST) begin
				next_rdata = hold[pidx][4'(offset)];
			end else if (offset == OFS_BE_HIGH) begin
				next_rdata = {2'h0, byte_en[pidx][13:8]};
			end else if (offset == OFS_BE_LOW) begin
				next_rdata = byte_en[pidx][7:0];
			end else if (offset == OFS_CONTROL) begin
				next_rdata = {1'b0, write_done[pidx], read_done[pidx],
					ctl_op[pidx], ctl_entry[pidx]};
			end else if (offset == OFS_FILTER) begin
				next_rdata = {7'h00, RING_FILTER_SINGLE[pidx]};
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RDATA  <= REG_RD ? next_rdata : 8'h00;
			REG_RVALID <= REG_RD;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	read_busy_a: assert property ((trig && !REG_WDATA[CTL_OP_BIT])
		|=> !read_done[cur_port] ##2 read_done[cur_port])
		else $error("read completion flag timing wrong");
	write_busy_a: assert property ((trig && REG_WDATA[CTL_OP_BIT])
		|=> !write_done[cur_port] ##2 write_done[cur_port])
		else $error("write completion flag timing wrong");
	entry_capture_a: assert property (trig
		|=> cur_entry == $past(REG_WDATA[3:0]))
		else $error("entry number not captured");
	op_capture_a: assert property (trig
		|=> ctl_op[cur_port] == cur_wr && cur_wr == $past(REG_WDATA[4]))
		else $error("operation type not captured");
	offset_step_a: assert property ((data_wr || data_rd)
		&& !(REG_WR && REG_ADDR == ADDR_OFFSET)
		|=> offset == $past(offset) + 8'h01)
		else $error("offset did not advance");
	bad_port_a: assert property ((REG_WR && REG_ADDR == ADDR_DATA && !port_ok)
		|=> $stable(RING_FILTER_SINGLE))
		else $error("unselected table was written");
	ctl_read_a: assert property ((data_rd && offset == OFS_CONTROL)
		|=> REG_RVALID && REG_RDATA[CTL_RDONE_BIT] == $past(read_done[pidx])
		&& REG_RDATA[CTL_WDONE_BIT] == $past(write_done[pidx]))
		else $error("control status read wrong");
	filter_set_a: assert property ((data_wr && offset == OFS_FILTER)
		|=> RING_FILTER_SINGLE[$past(pidx)] == $past(REG_WDATA[0]))
		else $error("filter option not stored");
	be_gate_a: assert property ((state == ST_FINISH && !cur_wr
		&& !byte_en[cur_port][13]) |=> $stable(hold[cur_port][0]))
		else $error("disabled byte was copied");
	write_seq_a: assert property ((state == ST_ACCESS) |=> state == ST_FINISH
		##1 state == ST_IDLE)
		else $error("operation sequence broken");

	read_op_c:   cover property (trig && !REG_WDATA[CTL_OP_BIT]
		##[3:8] data_rd);
	write_op_c:  cover property (trig && REG_WDATA[CTL_OP_BIT]);
	filter_on_c: cover property (data_wr && offset == OFS_FILTER
		&& REG_WDATA[0]);
	odd_be_c:    cover property (data_wr && offset == OFS_BE_LOW
		&& REG_WDATA == 8'h55);

endmodule : rti_rule_table

// File: rtl/rti_pkg.sv
package rti_pkg;

	// -----------------------------------------------------------------
	// direct register addresses of the indirect access scheme
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_SELECT = 8'h6e; // table, direction, port
	localparam logic [7:0] ADDR_OFFSET = 8'h6f; // byte location
	localparam logic [7:0] ADDR_DATA   = 8'ha0; // indirect data byte

	// -----------------------------------------------------------------
	// select register fields
	// -----------------------------------------------------------------
	localparam logic [2:0] SEL_TABLE_RULES = 3'h2; // bits 7:5 = 010
	localparam int         SEL_TABLE_MSB   = 7;
	localparam int         SEL_TABLE_LSB   = 5;
	localparam int         SEL_DIR_BIT     = 4;    // 1 = read, 0 = write
	localparam int         NUM_PORTS       = 5;
	localparam logic [3:0] PORT_FIRST      = 4'h1;
	localparam logic [3:0] PORT_LAST       = 4'h5;

	// -----------------------------------------------------------------
	// per-port locations
	// -----------------------------------------------------------------
	localparam int         ENTRY_BYTES  = 14;
	localparam int         ENTRIES      = 16;
	localparam logic [7:0] OFS_BYTE_LAST = 8'h0d;
	localparam logic [7:0] OFS_BE_HIGH  = 8'h10; // enable bits 13:8
	localparam logic [7:0] OFS_BE_LOW   = 8'h11; // enable bits 7:0
	localparam logic [7:0] OFS_CONTROL  = 8'h12;
	localparam logic [7:0] OFS_FILTER   = 8'h13;

	// -----------------------------------------------------------------
	// access control fields and reset values
	// -----------------------------------------------------------------
	localparam int         CTL_WDONE_BIT = 6;
	localparam int         CTL_RDONE_BIT = 5;
	localparam int         CTL_OP_BIT    = 4;    // 1 = write, 0 = read
	localparam logic       RST_OP        = 1'b0;
	localparam logic [3:0] RST_ENTRY     = 4'h0;
	localparam logic       RST_RDONE     = 1'b1;
	localparam logic       RST_WDONE     = 1'b1;
	localparam logic       RST_FILTER    = 1'b0;
	localparam logic [13:0] RST_BE       = 14'h0000;
	localparam logic [7:0] RST_SELECT    = 8'h00;
	localparam logic [7:0] RST_OFFSET    = 8'h00;

	// -----------------------------------------------------------------
	// entry operation sequencer
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACCESS = 2'b01,
		ST_FINISH = 2'b10
	} rti_state_t;

endpackage : rti_pkg

// File: rtl/rti_entry_mem.sv
`timescale 1ns/10ps

// -----------------------------------------------------------------
// rule entry storage, all ports, byte-masked write, registered read
// -----------------------------------------------------------------
module rti_entry_mem
	import rti_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         we,
	input  wire logic [2:0]   port_idx,
	input  wire logic [3:0]   entry,
	input  wire logic [13:0]  byte_en,
	input  wire logic [111:0] wdata,
	output logic      [111:0] rdata
);

	logic [6:0]   addr;

	// flat word address from port and entry
	assign addr = 7'({port_idx, 4'h0}) + 7'(entry);

	// one byte lane per entry byte, each with its own array, so that
	// no two processes write the same variable
	// enable bit j covers entry byte 0x0d - j; read is registered
	genvar k;
	generate
		for (k = 0; k < ENTRY_BYTES; k++) begin : g_byte
			logic [7:0] lane [0:NUM_PORTS*ENTRIES-1];
			always_ff @(posedge clk) begin
				if (we && byte_en[ENTRY_BYTES-1-k]) begin
					lane[addr] <= wdata[8*k +: 8];
				end
				rdata[8*k +: 8] <= lane[addr];
			end
		end
	endgenerate

endmodule : rti_entry_mem

// File: tb/test_rule_table_indirect_access.sv
`timescale 1ns/10ps

`define CHK(got, exp) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("FAIL %0t: got %h expected %h", $time, got, exp); \
	end \
end

module test_rule_table_indirect_access
	import rti_pkg::*;
;
	logic       REF_CLK;
	logic       RST;
	logic       REG_WR;
	logic       REG_RD;
	logic [7:0] REG_ADDR;
	logic [7:0] REG_WDATA;
	logic [7:0] REG_RDATA;
	logic       REG_RVALID;
	logic [4:0] RING_FILTER_SINGLE;
	int         num_errors;
	int         num_checks;
	logic [7:0] d;

	rti_rule_table i_dut (
		.REF_CLK            (REF_CLK),
		.RST                (RST),
		.REG_WR             (REG_WR),
		.REG_RD             (REG_RD),
		.REG_ADDR           (REG_ADDR),
		.REG_WDATA          (REG_WDATA),
		.REG_RDATA          (REG_RDATA),
		.REG_RVALID         (REG_RVALID),
		.RING_FILTER_SINGLE (RING_FILTER_SINGLE)
	);

	// ---------------------------------------------------------------
	// clock and watchdog
	// ---------------------------------------------------------------
	always #25 REF_CLK = ~REF_CLK;

	initial begin
		#1000000;
		num_errors++;
		end_sim();
	end

	// ---------------------------------------------------------------
	// register port access tasks
	// ---------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge REF_CLK);
		REG_WR = 1'b1;
		REG_ADDR = a;
		REG_WDATA = v;
		@(negedge REF_CLK);
		REG_WR = 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		int n;
		@(negedge REF_CLK);
		REG_RD = 1'b1;
		REG_ADDR = a;
		@(negedge REF_CLK);
		REG_RD = 1'b0;
		n = 0;
		while (REG_RVALID !== 1'b1 && n < 4) begin
			@(negedge REF_CLK);
			n++;
		end
		v = REG_RDATA;
		if (n == 4) begin
			num_errors++;
			$display("FAIL %0t: no read answer", $time);
		end
	endtask : reg_rd

	task automatic ind_wr(input logic [3:0] p, input logic [7:0] o,
		input logic [7:0] v);
		reg_wr(ADDR_SELECT, {SEL_TABLE_RULES, 1'b0, p});
		reg_wr(ADDR_OFFSET, o);
		reg_wr(ADDR_DATA, v);
	endtask : ind_wr

	task automatic ind_rd(input logic [3:0] p, input logic [7:0] o,
		output logic [7:0] v);
		reg_wr(ADDR_SELECT, {SEL_TABLE_RULES, 1'b1, p});
		reg_wr(ADDR_OFFSET, o);
		reg_rd(ADDR_DATA, v);
	endtask : ind_rd

	// ---------------------------------------------------------------
	// entry level helpers
	// ---------------------------------------------------------------
	task automatic set_be(input logic [3:0] p, input logic [7:0] h,
		input logic [7:0] l);
		ind_wr(p, OFS_BE_HIGH, h);
		ind_wr(p, OFS_BE_LOW, l);
	endtask : set_be

	// burst fill of the holding buffer, offset steps on its own
	task automatic fill(input logic [3:0] p, input logic [7:0] b);
		reg_wr(ADDR_SELECT, {SEL_TABLE_RULES, 1'b0, p});
		reg_wr(ADDR_OFFSET, 8'h00);
		for (int i = 0; i < ENTRY_BYTES; i++) begin
			reg_wr(ADDR_DATA, b + 8'(i));
		end
	endtask : fill

	// start an operation, then poll its done flag bounded
	task automatic commit(input logic [3:0] p, input logic [7:0] c);
		int n;
		logic [7:0] v;
		ind_wr(p, OFS_CONTROL, c);
		n = 0;
		v = 8'h00;
		do begin
			ind_rd(p, OFS_CONTROL, v);
			n++;
		end while (v[c[4] ? 6 : 5] !== 1'b1 && n < 30);
		`CHK(v[c[4] ? 6 : 5], 1'b1)
	endtask : commit

	// burst read of the holding buffer, even and odd base values
	task automatic read_burst(input logic [3:0] p, input logic [7:0] be,
		input logic [7:0] bo);
		logic [7:0] v;
		reg_wr(ADDR_SELECT, {SEL_TABLE_RULES, 1'b1, p});
		reg_wr(ADDR_OFFSET, 8'h00);
		for (int i = 0; i < ENTRY_BYTES; i++) begin
			reg_rd(ADDR_DATA, v);
			`CHK(v, ((i % 2) ? bo : be) + 8'(i))
		end
	endtask : read_burst

	// read one entry back with every byte enabled
	task automatic check_entry(input logic [3:0] p, input logic [3:0] e,
		input logic [7:0] be, input logic [7:0] bo);
		set_be(p, 8'h3f, 8'hff);
		commit(p, {4'h0, e});
		read_burst(p, be, bo);
	endtask : check_entry

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		REF_CLK = 1'b0;
		RST = 1'b1;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		num_errors = 0;
		num_checks = 0;
		repeat (5) @(posedge REF_CLK);
		@(negedge REF_CLK);
		RST = 1'b0;
		// reset values of control and filter option
		ind_rd(4'h1, OFS_CONTROL, d);
		`CHK(d, 8'h60)
		ind_rd(4'h3, OFS_FILTER, d);
		`CHK(d, 8'h00)
		// filter option bit and its reserved bits
		ind_wr(4'h3, OFS_FILTER, 8'hff);
		ind_rd(4'h3, OFS_FILTER, d);
		`CHK(d, 8'h01)
		`CHK(RING_FILTER_SINGLE, 5'h04)
		// another table type must not reach the rule table
		reg_wr(ADDR_SELECT, 8'h22);
		reg_wr(ADDR_OFFSET, OFS_FILTER);
		reg_wr(ADDR_DATA, 8'h01);
		`CHK(RING_FILTER_SINGLE, 5'h04)
		// entry 0 of every port, then entry 15 of port 1
		for (int p = 1; p <= NUM_PORTS; p++) begin
			set_be(4'(p), 8'h3f, 8'hff);
			fill(4'(p), 8'(p * 16));
			commit(4'(p), 8'h10);
		end
		fill(4'h1, 8'ha0);
		commit(4'h1, 8'h1f);
		ind_rd(4'h1, OFS_CONTROL, d);
		`CHK(d, 8'h7f)
		ind_rd(4'h1, OFS_BE_HIGH, d);
		`CHK(d, 8'h3f)
		// data read with write direction selected gives nothing
		reg_wr(ADDR_SELECT, 8'h41);
		reg_wr(ADDR_OFFSET, OFS_BE_HIGH);
		reg_rd(ADDR_DATA, d);
		`CHK(d, 8'h00)
		for (int p = 1; p <= NUM_PORTS; p++) begin
			check_entry(4'(p), 4'h0, 8'(p * 16), 8'(p * 16));
		end
		check_entry(4'h1, 4'hf, 8'ha0, 8'ha0);
		ind_rd(4'h1, OFS_CONTROL, d);
		`CHK(d, 8'h6f)
		// odd byte commit over a full entry on port 5
		set_be(4'h5, 8'h3f, 8'hff);
		fill(4'h5, 8'h60);
		commit(4'h5, 8'h1f);
		set_be(4'h5, 8'h15, 8'h55);
		ind_rd(4'h5, OFS_BE_LOW, d);
		`CHK(d, 8'h55)
		fill(4'h5, 8'hc0);
		commit(4'h5, 8'h1f);
		check_entry(4'h5, 4'hf, 8'h60, 8'hc0);
		// read of entry 0 with odd enables keeps the even buffer bytes
		set_be(4'h5, 8'h15, 8'h55);
		commit(4'h5, 8'h00);
		read_burst(4'h5, 8'h60, 8'h50);
		end_sim();
	end

endmodule : test_rule_table_indirect_access
